/* inc/ppc_pkg.sv */
package ppc_pkg;

	// Number of coprocessor use bits.
	localparam int NUM_CP = 3;

	// Kind of operation presented for checking.
	typedef enum logic [1:0] {
		PPC_OP_INSTR  = 2'h0,
		PPC_OP_SYSREG = 2'h1
	} ppc_op_t;

	// Required authority level of the instruction or register.
	typedef enum logic [1:0] {
		PPC_LVL_USER = 2'h0,
		PPC_LVL_SV   = 2'h1,
		PPC_LVL_HV   = 2'h2
	} ppc_lvl_t;

	// Handling of a hypervisor-level item when virtualization is off.
	typedef enum logic [1:0] {
		PPC_CONV_RESERVED = 2'h0,
		PPC_CONV_SV       = 2'h1,
		PPC_CONV_CACHE    = 2'h2
	} ppc_conv_t;

	// Verdict, one-hot coded.
	typedef enum logic [3:0] {
		PPC_V_OK   = 4'h1,
		PPC_V_RIE  = 4'h2,
		PPC_V_PIE  = 4'h4,
		PPC_V_UCP  = 4'h8
	} ppc_verdict_t;

	// Interrupt status bit positions.
	localparam int ST_RIE = 0;
	localparam int ST_PIE = 1;
	localparam int ST_UCP = 2;
	localparam int ST_W   = 3;

	// Check state machine, one-hot.
	typedef enum logic [1:0] {
		PPC_S_IDLE = 2'h1,
		PPC_S_DONE = 2'h2
	} ppc_state_t;

	// Register map of the status, mask, mode and last-verdict registers.
	localparam logic [1:0] ADDR_STATUS = 2'h0;
	localparam logic [1:0] ADDR_MASK   = 2'h1;
	localparam logic [1:0] ADDR_MODE   = 2'h2;
	localparam logic [1:0] ADDR_LAST   = 2'h3;
	localparam logic [ST_W-1:0] MASK_RESET = 3'h0;

endpackage : ppc_pkg

/* inc/ppc_auth_if.sv */
`timescale 1ns/1ns
// Carries the decoded authority between the decoder and the checker.
interface ppc_auth_if;
	logic hv_auth;
	logic sv_auth;
	logic host_mode;
	modport src (output hv_auth, output sv_auth, output host_mode);
	modport dst (input hv_auth, input sv_auth, input host_mode);
endinterface : ppc_auth_if

/* hdl/ppc_auth.sv */
`timescale 1ns/1ns
// Decodes the operating mode flags into the current authority.
module ppc_auth (
	input  wire logic virtualization_enable_flag_in,
	input  wire logic guest_state_flag_in,
	input  wire logic user_level_flag_in,
	ppc_auth_if.src   auth
);
	// Hypervisor only in host supervisor state with virtualization on.
	assign auth.hv_auth   = virtualization_enable_flag_in & ~guest_state_flag_in
		& ~user_level_flag_in; // see RULE1 see RULE2
	// Supervisor whenever the user flag is clear, hypervisor included.
	assign auth.sv_auth   = ~user_level_flag_in; // see RULE3 see RULE17
	// Host mode ignores the user flag for mode-dependent functions.
	assign auth.host_mode = virtualization_enable_flag_in & ~guest_state_flag_in; // see RULE18
endmodule : ppc_auth

/* hdl/ppc_checker.sv */
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
// Behaviour
// RULE1: Hypervisor authority only in host supervisor state.
// RULE2: No hypervisor authority without virtualization enabled.
// RULE3: User flag clear grants supervisor authority.
// RULE4: User flag set blocks privileged instructions.
// RULE5: Hypervisor instruction, virtualization off gives reserved.
// RULE6: Conventional hypervisor instruction: reserved or supervisor.
// RULE7: Conventional cache maintenance judged as supervisor.
// RULE8: Violation reports exactly one of three exceptions.
// RULE9: Clear coprocessor use bit gives unusable.
// RULE10: Use bits checked independently of mode.
// RULE11: Unimplemented coprocessor use bit stays zero.
// RULE12: Coprocessor instructions user level; others execute.
// RULE13: Conventional hypervisor register in user mode: privilege.
// RULE14: Conventional hypervisor register: undefined or supervisor.
// RULE15: Supervisor coprocessor register: unusable, privilege, else ok.
// RULE16: Legality from mode flags and use bits.
// RULE17: Hypervisor authority includes supervisor rights.
// RULE18: Host user state is user authority for checks.
// RULE19: Verdict given before any state update.
module ppc_checker #(
	parameter logic [ppc_pkg::NUM_CP-1:0] CP_IMPL = 3'h7
) (
	input  wire logic                          clk_sys_in,
	input  wire logic                          nrst_in,
	input  wire logic                          clk_en_in,
	input  wire logic                          virtualization_enable_flag_in,
	input  wire logic                          guest_state_flag_in,
	input  wire logic                          user_level_flag_in,
	input  wire logic [ppc_pkg::NUM_CP-1:0]    cp_use_wr_in,
	input  wire logic                          cp_use_we_in,
	input  wire logic                          req_valid_in,
	input  wire ppc_pkg::ppc_op_t              req_op_in,
	input  wire ppc_pkg::ppc_lvl_t             req_lvl_in,
	input  wire ppc_pkg::ppc_conv_t            req_conv_in,
	input  wire logic                          req_is_cp_in,
	input  wire logic [1:0]                    req_cp_idx_in,
	input  wire logic                          reg_wr_in,
	input  wire logic                          reg_rd_in,
	input  wire logic [1:0]                    reg_addr_in,
	input  wire logic [31:0]                   reg_wdata_in,
	output logic      [31:0]                   reg_rdata_out,
	output logic      [ppc_pkg::NUM_CP-1:0]    cp_use_out,
	output logic                               host_mode_out,
	output logic                               allow_out,
	output logic                               commit_ok_out,
	output logic                               reserved_instr_exception_out,
	output logic                               privileged_instr_exception_out,
	output logic                               coproc_unusable_exception_out,
	output logic                               verdict_valid_out,
	output logic                               irq_out
);
	import ppc_pkg::*;

	ppc_auth_if auth_i ();

	////////////////////////////////////////////////////////////////////////////
	// Authority decode.

	// The decoder turns the three mode flags into authority levels.
	ppc_auth u_auth (
		.virtualization_enable_flag_in (virtualization_enable_flag_in),
		.guest_state_flag_in           (guest_state_flag_in),
		.user_level_flag_in            (user_level_flag_in),
		.auth                          (auth_i)
	);

	assign host_mode_out = auth_i.host_mode; // see RULE18

	////////////////////////////////////////////////////////////////////////////
	// Coprocessor use bits.

	logic [NUM_CP-1:0] cp_use_r;
	logic [NUM_CP-1:0] cp_use_nxt;

	// Each bit can only be set if its coprocessor exists.
	generate
		for (genvar g = 0; g < NUM_CP; g++) begin : g_cp
			always_comb begin
				cp_use_nxt[g] = cp_use_r[g];
				if (cp_use_we_in) begin
					cp_use_nxt[g] = cp_use_wr_in[g] & CP_IMPL[g]; // see RULE11
				end
			end
		end
	endgenerate

	// Registers the use bits.
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cp_use_r <= '0;
		end else if (clk_en_in) begin
			cp_use_r <= cp_use_nxt;
		end
	end

	assign cp_use_out = cp_use_r;

	////////////////////////////////////////////////////////////////////////////
	// Combinational verdict.

	ppc_verdict_t verdict;
	logic         cp_ok;

	// The addressed use bit; an out-of-range index reads as clear.
	always_comb begin
		cp_ok = 1'b0;
		if (req_cp_idx_in < 2'(NUM_CP)) begin
			cp_ok = cp_use_r[req_cp_idx_in]; // see RULE9 see RULE10
		end
	end

	// One exception is chosen per request, never two.
	always_comb begin
		verdict = PPC_V_OK; // see RULE8 see RULE16
		case (req_lvl_in)
			PPC_LVL_HV: begin
				if (!virtualization_enable_flag_in) begin
					// Conventional mode: handled per item.
					if (req_conv_in == PPC_CONV_CACHE || req_conv_in == PPC_CONV_SV) begin
						verdict = auth_i.sv_auth ? PPC_V_OK : PPC_V_PIE; // see RULE6 see RULE7
					end else if (req_op_in == PPC_OP_SYSREG) begin
						// Undefined register: supervisor needed to touch it.
						verdict = auth_i.sv_auth ? PPC_V_OK : PPC_V_PIE; // see RULE13 see RULE14
					end else begin
						verdict = PPC_V_RIE; // see RULE5
					end
				end else begin
					verdict = auth_i.hv_auth ? PPC_V_OK : PPC_V_PIE; // see RULE1 see RULE5 see RULE4
				end
			end
			PPC_LVL_SV: begin
				if (req_is_cp_in) begin
					if (!cp_ok) begin
						verdict = PPC_V_UCP; // see RULE15 see RULE10
					end else if (!auth_i.sv_auth) begin
						verdict = PPC_V_PIE; // see RULE15
					end
				end else if (!auth_i.sv_auth) begin
					verdict = PPC_V_PIE; // see RULE4 see RULE3 see RULE17
				end
			end
			PPC_LVL_USER: begin
				// No mode check at all on user-level items.
				if (req_is_cp_in && !cp_ok) begin
					verdict = PPC_V_UCP; // see RULE12 see RULE9
				end
			end
			default: begin
				verdict = PPC_V_RIE;
			end
		endcase
	end

	// Combinational permit lets the pipeline suppress commit in the same cycle.
	assign commit_ok_out = req_valid_in && verdict == PPC_V_OK; // see RULE19

	////////////////////////////////////////////////////////////////////////////
	// Registered verdict outputs.

	ppc_state_t   state_r;
	ppc_state_t   state_nxt;
	ppc_verdict_t vres_r;
	ppc_verdict_t vres_nxt;

	// Captures the verdict of each valid request for one cycle.
	always_comb begin
		state_nxt = state_r;
		vres_nxt  = vres_r;
		case (state_r)
			PPC_S_IDLE: begin
				if (req_valid_in) begin
					state_nxt = PPC_S_DONE;
					vres_nxt  = verdict;
				end
			end
			PPC_S_DONE: begin
				if (req_valid_in) begin
					vres_nxt = verdict;
				end else begin
					state_nxt = PPC_S_IDLE;
					vres_nxt  = PPC_V_OK;
				end
			end
			default: begin
				state_nxt = PPC_S_IDLE;
				vres_nxt  = PPC_V_OK;
			end
		endcase
	end

	// Registers the verdict state.
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_r <= PPC_S_IDLE;
			vres_r  <= PPC_V_OK;
		end else if (clk_en_in) begin
			state_r <= state_nxt;
			vres_r  <= vres_nxt;
		end
	end

	assign verdict_valid_out              = (state_r == PPC_S_DONE);
	assign allow_out                      = verdict_valid_out && vres_r == PPC_V_OK;
	assign reserved_instr_exception_out   = verdict_valid_out && vres_r == PPC_V_RIE;
	assign privileged_instr_exception_out = verdict_valid_out && vres_r == PPC_V_PIE;
	assign coproc_unusable_exception_out  = verdict_valid_out && vres_r == PPC_V_UCP;

	////////////////////////////////////////////////////////////////////////////
	// Interrupt status, mask and register port.

	logic [ST_W-1:0] status_r;
	logic [ST_W-1:0] status_nxt;
	logic [ST_W-1:0] mask_r;
	logic [ST_W-1:0] mask_nxt;
	logic [31:0]     rdata_r;
	logic [31:0]     rdata_nxt;
	logic [ST_W-1:0] ev;

	assign ev = {(req_valid_in && verdict == PPC_V_UCP),
	             (req_valid_in && verdict == PPC_V_PIE),
	             (req_valid_in && verdict == PPC_V_RIE)};

	// Write-one-to-clear status; a new event wins over a clear.
	always_comb begin
		status_nxt = status_r;
		mask_nxt   = mask_r;
		rdata_nxt  = '0;
		if (reg_wr_in && reg_addr_in == ADDR_STATUS) begin
			status_nxt = status_r & ~reg_wdata_in[ST_W-1:0];
		end
		if (reg_wr_in && reg_addr_in == ADDR_MASK) begin
			mask_nxt = reg_wdata_in[ST_W-1:0];
		end
		status_nxt = status_nxt | ev;
		if (reg_rd_in) begin
			case (reg_addr_in)
				ADDR_STATUS: rdata_nxt = {29'h0, status_r};
				ADDR_MASK:   rdata_nxt = {29'h0, mask_r};
				ADDR_MODE:   rdata_nxt = {25'h0, auth_i.host_mode, auth_i.sv_auth,
				                          auth_i.hv_auth, 1'b0, cp_use_r};
				ADDR_LAST:   rdata_nxt = {28'h0, vres_r};
				default:     rdata_nxt = '0;
			endcase
		end
	end

	// Registers status, mask and read data.
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			status_r <= '0;
			mask_r   <= MASK_RESET;
			rdata_r  <= '0;
		end else if (clk_en_in) begin
			status_r <= status_nxt;
			mask_r   <= mask_nxt;
			rdata_r  <= rdata_nxt;
		end
	end

	assign reg_rdata_out = rdata_r;
	assign irq_out       = |(status_r & mask_r);

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	property p_hv_auth;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		auth_i.hv_auth |-> virtualization_enable_flag_in && !guest_state_flag_in
			&& !user_level_flag_in;
	endproperty
	a_hv_auth: assert property (p_hv_auth) // see RULE1
		else $error("Hypervisor authority wrongly granted.");

	property p_no_hv_conv;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		!virtualization_enable_flag_in |-> !auth_i.hv_auth;
	endproperty
	a_no_hv_conv: assert property (p_no_hv_conv) // see RULE2
		else $error("Hypervisor in conventional mode.");

	property p_sv_exec;
		@(posedge clk_sys_in) disable iff (!nrst_in || !clk_en_in)
		req_valid_in && req_lvl_in == PPC_LVL_SV && !req_is_cp_in && !user_level_flag_in
			|=> allow_out;
	endproperty
	a_sv_exec: assert property (p_sv_exec) // see RULE3
		else $error("Supervisor instruction refused.");

	property p_user_block;
		@(posedge clk_sys_in) disable iff (!nrst_in || !clk_en_in)
		req_valid_in && req_lvl_in == PPC_LVL_SV && req_op_in == PPC_OP_INSTR
			&& user_level_flag_in |=> privileged_instr_exception_out;
	endproperty
	a_user_block: assert property (p_user_block) // see RULE4
		else $error("User privileged not blocked.");

	sequence s_hv_instr_conv;
		req_valid_in && req_lvl_in == PPC_LVL_HV && req_op_in == PPC_OP_INSTR
			&& req_conv_in == PPC_CONV_RESERVED && !virtualization_enable_flag_in;
	endsequence
	property p_rie;
		@(posedge clk_sys_in) disable iff (!nrst_in || !clk_en_in)
		s_hv_instr_conv |=> reserved_instr_exception_out ##0 !allow_out;
	endproperty
	a_rie: assert property (p_rie) else $error("Reserved exception missing."); // see RULE5

	property p_cache;
		@(posedge clk_sys_in) disable iff (!nrst_in || !clk_en_in)
		req_valid_in && req_lvl_in == PPC_LVL_HV && req_conv_in == PPC_CONV_CACHE
			&& !virtualization_enable_flag_in |=> !reserved_instr_exception_out;
	endproperty
	a_cache: assert property (p_cache) else $error("Cache op raised reserved."); // see RULE7

	property p_one_hot;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		$onehot0({reserved_instr_exception_out, privileged_instr_exception_out,
			coproc_unusable_exception_out, allow_out});
	endproperty
	a_one_hot: assert property (p_one_hot) else $error("More than one verdict."); // see RULE8

	property p_ucp;
		@(posedge clk_sys_in) disable iff (!nrst_in || !clk_en_in)
		req_valid_in && req_is_cp_in && !cp_ok && req_lvl_in != PPC_LVL_HV
			|=> coproc_unusable_exception_out;
	endproperty
	a_ucp: assert property (p_ucp) else $error("Unusable exception missing."); // see RULE9

	property p_unimpl;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(cp_use_r & ~CP_IMPL) == '0;
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("Unimplemented use bit set."); // see RULE11

	property p_user_ok;
		@(posedge clk_sys_in) disable iff (!nrst_in || !clk_en_in)
		req_valid_in && req_lvl_in == PPC_LVL_USER && !req_is_cp_in |=> allow_out;
	endproperty
	a_user_ok: assert property (p_user_ok) else $error("User instruction refused."); // see RULE12

	property p_commit;
		@(posedge clk_sys_in) disable iff (!nrst_in || !clk_en_in)
		req_valid_in && !commit_ok_out |=> !allow_out;
	endproperty
	a_commit: assert property (p_commit) else $error("Commit and verdict disagree."); // see RULE19

endmodule : ppc_checker

/* sim/ppc_decode_model.sv */
`timescale 1ns/1ns
// Stands in for the decode stage: presents one check request and collects its verdict.
module ppc_decode_model (
	input  wire logic           clk_sys_in,
	input  wire logic           commit_ok_in,
	input  wire logic [3:0]     verdict_in,
	input  wire logic           verdict_valid_in,
	output logic                req_valid_out,
	output ppc_pkg::ppc_op_t    req_op_out,
	output ppc_pkg::ppc_lvl_t   req_lvl_out,
	output ppc_pkg::ppc_conv_t  req_conv_out,
	output logic                req_is_cp_out,
	output logic [1:0]          req_cp_idx_out
);
	import ppc_pkg::*;

	// Idle request lines at time zero.
	initial begin
		req_valid_out = 1'b0;
		req_op_out = PPC_OP_INSTR;
		req_lvl_out = PPC_LVL_USER;
		req_conv_out = PPC_CONV_RESERVED;
		req_is_cp_out = 1'b0;
		req_cp_idx_out = 2'h0;
	end

	// One request for one cycle; the qualifiers are scrambled afterwards so nothing leans on them.
	task automatic issue(input ppc_op_t op, input ppc_lvl_t lvl, input ppc_conv_t cv,
			input logic cp, input logic [1:0] ix, output logic ok, output logic [3:0] vd,
			output logic vv);
		@(posedge clk_sys_in);
		req_valid_out <= 1'b1;
		req_op_out <= op;
		req_lvl_out <= lvl;
		req_conv_out <= cv;
		req_is_cp_out <= cp;
		req_cp_idx_out <= ix;
		#1;
		ok = commit_ok_in;
		@(posedge clk_sys_in);
		req_valid_out <= 1'b0;
		req_op_out <= ppc_op_t'(~op);
		req_lvl_out <= ppc_lvl_t'(~lvl);
		req_conv_out <= ppc_conv_t'(~cv);
		req_is_cp_out <= ~cp;
		req_cp_idx_out <= ~ix;
		#1;
		vd = verdict_in;
		vv = verdict_valid_in;
	endtask : issue
endmodule : ppc_decode_model

/* sim/privilege_permission_checker_tb.sv */
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
	err_total++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
// Self-checking bench for the privilege checker.
module privilege_permission_checker_tb;
	import ppc_pkg::*;
	logic        clk_sys_in, nrst_in, clk_en, cp_we, req_valid, req_is_cp;
	logic        reg_wr, reg_rd, host_mode, allow, commit_ok, reserved_instr_exception, privileged_instr_exception, ucp, vvalid, irq;
	logic [2:0]  mode, cp_wr, cp_use, cu_exp;
	logic [1:0]  req_idx, reg_addr;
	logic [31:0] reg_wdata, rdata, d;
	ppc_op_t     req_op;
	ppc_lvl_t    req_lvl;
	ppc_conv_t   req_conv;
	int          err_total, checked;

	ppc_checker #(.CP_IMPL(3'h3)) DUT (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
		.clk_en_in(clk_en), .virtualization_enable_flag_in(mode[2]),
		.guest_state_flag_in(mode[1]), .user_level_flag_in(mode[0]), .cp_use_wr_in(cp_wr),
		.cp_use_we_in(cp_we), .req_valid_in(req_valid), .req_op_in(req_op),
		.req_lvl_in(req_lvl), .req_conv_in(req_conv), .req_is_cp_in(req_is_cp),
		.req_cp_idx_in(req_idx), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_rdata_out(rdata),
		.cp_use_out(cp_use), .host_mode_out(host_mode), .allow_out(allow),
		.commit_ok_out(commit_ok), .reserved_instr_exception_out(reserved_instr_exception),
		.privileged_instr_exception_out(privileged_instr_exception), .coproc_unusable_exception_out(ucp),
		.verdict_valid_out(vvalid), .irq_out(irq));
	ppc_decode_model PTN (.clk_sys_in(clk_sys_in), .commit_ok_in(commit_ok),
		.verdict_in({ucp, privileged_instr_exception, reserved_instr_exception, allow}), .verdict_valid_in(vvalid),
		.req_valid_out(req_valid), .req_op_out(req_op), .req_lvl_out(req_lvl),
		.req_conv_out(req_conv), .req_is_cp_out(req_is_cp), .req_cp_idx_out(req_idx));

	// Free-running 100 MHz clock.
	initial begin
		clk_sys_in = 1'b0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end

	// Expected verdict from the mode flags {virt, guest, user} and the use bits.
	function automatic ppc_verdict_t exp_v(input logic [2:0] m, input logic [2:0] cu,
			input ppc_op_t op, input ppc_lvl_t lvl, input ppc_conv_t cv, input logic cp,
			input logic [1:0] ix);
		logic cuok;
		cuok = (ix < 2'h3) ? cu[ix] : 1'b0;
		if (lvl == PPC_LVL_HV) begin
			if (m[2]) return (!m[1] && !m[0]) ? PPC_V_OK : PPC_V_PIE;
			if (op == PPC_OP_INSTR && cv == PPC_CONV_RESERVED) return PPC_V_RIE;
			return m[0] ? PPC_V_PIE : PPC_V_OK;
		end
		if (cp && !cuok) return PPC_V_UCP;
		if (lvl == PPC_LVL_SV && m[0]) return PPC_V_PIE;
		return PPC_V_OK;
	endfunction : exp_v

	// One register write cycle.
	task automatic reg_wr_t(input logic [1:0] a, input logic [31:0] v);
		@(posedge clk_sys_in);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk_sys_in);
		reg_wr <= 1'b0;
		reg_wdata <= ~v;
		#1;
	endtask : reg_wr_t

	// One register read cycle; data taken in the following cycle.
	task automatic reg_rd_t(input logic [1:0] a, output logic [31:0] v);
		@(posedge clk_sys_in);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys_in);
		reg_rd <= 1'b0;
		#1;
		v = rdata;
	endtask : reg_rd_t

	// Changes the operating mode flags.
	task automatic set_mode(input logic [2:0] m);
		@(posedge clk_sys_in);
		mode <= m;
		#1;
	endtask : set_mode

	// Writes the coprocessor use bits; only implemented ones may stick.
	task automatic set_cu(input logic [2:0] v);
		@(posedge clk_sys_in);
		cp_we <= 1'b1;
		cp_wr <= v;
		@(posedge clk_sys_in);
		cp_we <= 1'b0;
		#1;
		cu_exp = v & 3'h3;
		`CHK("cp_use", cu_exp, cp_use)
	endtask : set_cu

	// Presents one operation and judges the answer.
	task automatic chk_op(input string nm, input ppc_op_t op, input ppc_lvl_t lvl,
			input ppc_conv_t cv, input logic cp, input logic [1:0] ix);
		ppc_verdict_t e;
		logic         ok;
		logic         vv;
		logic [3:0]   vd;
		e = exp_v(mode, cu_exp, op, lvl, cv, cp, ix);
		PTN.issue(op, lvl, cv, cp, ix, ok, vd, vv);
		`CHK(nm, e, vd)
		`CHK("commit_ok", e == PPC_V_OK, ok)
		`CHK("verdict_valid", 1'b1, vv)
	endtask : chk_op

	// Reset values of the use bits and the mask register.
	task automatic t_reset;
		`CHK("cp_use", 3'h0, cp_use)
		reg_rd_t(ADDR_MASK, d);
		`CHK("mask", {29'h0, MASK_RESET}, d)
		$display("t_reset done");
	endtask : t_reset

	// Every mode combination against every privilege class.
	task automatic t_modes;
		logic [2:0] ae;
		set_cu(3'h3);
		for (int i = 0; i < 8; i++) begin
			set_mode(i[2:0]);
			`CHK("host_mode", mode[2] & ~mode[1], host_mode)
			reg_rd_t(ADDR_MODE, d);
			ae = {mode[2] & ~mode[1], ~mode[0], mode[2] & ~mode[1] & ~mode[0]};
			`CHK("auth", ae, d[6:4])
			`CHK("mode_cu", {1'b0, cu_exp}, d[3:0])
			chk_op("sv_instr", PPC_OP_INSTR, PPC_LVL_SV, PPC_CONV_RESERVED, 1'b0, 2'h0);
			chk_op("hv_res", PPC_OP_INSTR, PPC_LVL_HV, PPC_CONV_RESERVED, 1'b0, 2'h0);
			chk_op("hv_sv", PPC_OP_INSTR, PPC_LVL_HV, PPC_CONV_SV, 1'b0, 2'h0);
			chk_op("cache", PPC_OP_INSTR, PPC_LVL_HV, PPC_CONV_CACHE, 1'b0, 2'h0);
			chk_op("hv_reg", PPC_OP_SYSREG, PPC_LVL_HV, PPC_CONV_RESERVED, 1'b0, 2'h0);
			chk_op("sv_reg", PPC_OP_SYSREG, PPC_LVL_SV, PPC_CONV_SV, 1'b0, 2'h0);
			chk_op("user", PPC_OP_INSTR, PPC_LVL_USER, PPC_CONV_SV, 1'b0, 2'h0);
		end
		$display("t_modes done");
	endtask : t_modes

	// Use bits judged alone, in the highest and lowest authority.
	task automatic t_coproc;
		for (int k = 0; k < 2; k++) begin
			set_cu(k ? 3'h7 : 3'h0);
			for (int m = 0; m < 2; m++) begin
				set_mode(m ? 3'h1 : 3'h4);
				for (int ix = 0; ix < 4; ix++) begin
					chk_op("cp_ins", PPC_OP_INSTR, PPC_LVL_USER, PPC_CONV_RESERVED, 1'b1, ix[1:0]);
					chk_op("cp_sv", PPC_OP_SYSREG, PPC_LVL_SV, PPC_CONV_RESERVED, 1'b1, ix[1:0]);
					chk_op("cp_um", PPC_OP_SYSREG, PPC_LVL_USER, PPC_CONV_SV, 1'b1, ix[1:0]);
				end
			end
		end
		$display("t_coproc done");
	endtask : t_coproc

	// Sticky status, masking, clearing and the read-only mode register.
	task automatic t_irq;
		reg_wr_t(ADDR_MASK, 32'h0);
		reg_wr_t(ADDR_STATUS, 32'h7);
		reg_rd_t(ADDR_STATUS, d);
		`CHK("status", 32'h0, d)
		set_mode(3'h1);
		chk_op("pie", PPC_OP_INSTR, PPC_LVL_SV, PPC_CONV_RESERVED, 1'b0, 2'h0);
		reg_rd_t(ADDR_STATUS, d);
		`CHK("status", 32'h2, d)
		`CHK("irq", 1'b0, irq)
		reg_rd_t(ADDR_LAST, d);
		`CHK("last", {28'h0, PPC_V_OK}, d)
		reg_wr_t(ADDR_MASK, 32'h2);
		`CHK("irq", 1'b1, irq)
		set_mode(3'h0);
		chk_op("rie", PPC_OP_INSTR, PPC_LVL_HV, PPC_CONV_RESERVED, 1'b0, 2'h0);
		reg_rd_t(ADDR_STATUS, d);
		`CHK("status", 32'h3, d)
		reg_wr_t(ADDR_STATUS, 32'h2);
		`CHK("irq", 1'b0, irq)
		reg_wr_t(ADDR_MODE, 32'h0);
		reg_rd_t(ADDR_MODE, d);
		`CHK("mode_ro", {25'h0, 7'h20 | {4'h0, cu_exp}}, d)
		$display("t_irq done");
	endtask : t_irq

	// Clock enable low freezes state; a reset in mid-run clears it again.
	task automatic t_freeze;
		@(posedge clk_sys_in);
		clk_en <= 1'b0;
		reg_wr_t(ADDR_MASK, 32'h7);
		@(posedge clk_sys_in);
		clk_en <= 1'b1;
		reg_rd_t(ADDR_MASK, d);
		`CHK("mask_frozen", 32'h2, d)
		@(posedge clk_sys_in);
		nrst_in <= 1'b0;
		@(posedge clk_sys_in);
		nrst_in <= 1'b1;
		cu_exp = 3'h0;
		#1;
		`CHK("cp_use", 3'h0, cp_use)
		reg_rd_t(ADDR_STATUS, d);
		`CHK("status_rst", 32'h0, d)
		reg_rd_t(ADDR_MASK, d);
		`CHK("mask_rst", {29'h0, MASK_RESET}, d)
		$display("t_freeze done");
	endtask : t_freeze

	// Prints the counts and the verdict, then stops.
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test

	// Main sequence.
	initial begin
		err_total = 0;
		checked = 0;
		nrst_in = 1'b0;
		clk_en = 1'b1;
		mode = 3'h0;
		cp_wr = 3'h0;
		cp_we = 1'b0;
		cu_exp = 3'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 2'h0;
		reg_wdata = 32'h0;
		repeat (10) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		t_reset;
		t_modes;
		t_coproc;
		t_irq;
		t_freeze;
		finish_test;
	end

	// Cuts a hang short well beyond the expected few hundred cycles.
	initial begin
		#100000;
		err_total++;
		$display("[ERR] watchdog expired");
		finish_test;
	end
endmodule : privilege_permission_checker_tb
